// ===== rtl/stream_core.sv
// Core end: streaming transmit and receive with init debounce and clocking
`timescale 1ns/1ps
`include "stream_link_defs.svh"

// Notes on behaviour
// - User fills every byte of each word
// - Valid gaps carried except during compensation
// - User takes each receive word immediately
// - Word moves when ready and valid high
// - Core may drop ready to stall user
// - Init request registered and debounced first
// - Debounce cycles derived from MCLK_MHZ, INIT_CLK_MHZ unused
// - Not-locked input is inverse PLL lock
// - Status output high when helper active
// - One user clock for core and user
// - Buffered transmit clock makes user clock
// - Buffer clear drives clock module locked
// - Sync clock runs twice user clock
module stream_core
    import stream_link_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       reset,
    stream_link_if.core     link,
    input  wire logic       helper_active,
    input  wire logic       pll_locked,
    input  wire logic       far_valid,
    input  wire word_t      far_data,
    output logic            line_valid,
    output word_t           line_data,
    output logic            line_idle,
    output logic            line_comp
);

    // ----------------------------------------------------------------
    // Init request debounce
    // ----------------------------------------------------------------
    logic                   init_sync;
    logic                   init_stable;
    logic [`CNT_WIDTH-1:0]  deb_cnt;
    logic                   next_init_stable;
    logic [`CNT_WIDTH-1:0]  next_deb_cnt;

    always_comb begin
        next_init_stable = init_stable;
        next_deb_cnt     = '0;
        if (init_sync != init_stable) begin
            if (deb_cnt == `CNT_WIDTH'(`DEBOUNCE_CYCLES - 1)) begin
                next_init_stable = init_sync;
            end else begin
                next_deb_cnt = deb_cnt + `CNT_WIDTH'(1);
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            init_sync   <= 1'b1;
            init_stable <= 1'b1;
            deb_cnt     <= '0;
        end else begin
            init_sync   <= link.init_request;
            init_stable <= next_init_stable;
            deb_cnt     <= next_deb_cnt;
        end
    end

    // ----------------------------------------------------------------
    // Clock status and channel state
    // ----------------------------------------------------------------
    logic up;
    logic next_up;
    logic status_q;
    logic clear_q;

    always_comb begin
        next_up = ~init_stable & ~link.clock_not_locked;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            up       <= 1'b0;
            status_q <= 1'b0;
            clear_q  <= 1'b1;
        end else begin
            up       <= next_up;
            status_q <= helper_active;
            clear_q  <= ~pll_locked;
        end
    end

    assign link.channel_up             = up;
    assign link.clock_status_out       = status_q;
    assign link.clock_buffer_clear_out = clear_q;

    // ----------------------------------------------------------------
    // Transmit: gearbox pause and clock compensation
    // ----------------------------------------------------------------
    tx_state_e                state;
    tx_state_e                next_state;
    logic [4:0]               gb_cnt;
    logic [4:0]               next_gb_cnt;
    logic [`CC_WIDTH-1:0]     cc_cnt;
    logic [`CC_WIDTH-1:0]     next_cc_cnt;
    logic                     ready_q;
    logic                     next_ready;
    logic                     lv_q;
    logic                     next_lv;
    word_t                    ld_q;
    word_t                    next_ld;
    logic                     li_q;
    logic                     next_li;
    logic                     lc_q;
    logic                     next_lc;
    logic                     accept;

    // Compensation interval end, shared by counter wrap and state entry
    function automatic logic cc_wrap(input logic [`CC_WIDTH-1:0] cnt);
        return cnt == `CC_WIDTH'(`CC_INTERVAL - 1);
    endfunction

    // Beat taken only when both sides agree in the same cycle
    assign accept = ready_q & link.tx_valid;

    always_comb begin
        next_state  = state;
        next_gb_cnt = gb_cnt;
        next_cc_cnt = cc_cnt;
        next_ready  = 1'b0;
        next_lv     = accept;
        next_ld     = accept ? link.tx_data : ld_q;
        next_li     = ~accept;
        next_lc     = 1'b0;
        if (!next_up) begin
            next_state  = ST_DOWN;
            next_gb_cnt = '0;
            next_cc_cnt = '0;
        end else begin
            next_cc_cnt = cc_wrap(cc_cnt) ? '0 : cc_cnt + `CC_WIDTH'(1);
            next_gb_cnt = gb_cnt + 5'd1;
            unique case (state)
                ST_DOWN: begin
                    next_state = ST_DATA;
                    next_ready = 1'b1;
                end
                ST_DATA: begin
                    next_ready = 1'b1;
                    if (cc_wrap(cc_cnt)) begin
                        next_state = ST_COMP;
                        next_ready = 1'b0;
                    end else if (gb_cnt == 5'(`GEARBOX_PERIOD - 2)) begin
                        next_state = ST_PAUSE;
                        next_ready = 1'b0;
                    end
                end
                ST_PAUSE: begin
                    next_state = ST_DATA;
                    next_ready = 1'b1;
                end
                ST_COMP: begin
                    // Compensation blocks replace idles, gaps not kept
                    next_li = 1'b0;
                    next_lc = 1'b1;
                    if (cc_cnt == `CC_WIDTH'(`CC_LENGTH - 1)) begin
                        next_state = ST_DATA;
                        next_ready = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state   <= ST_DOWN;
            gb_cnt  <= '0;
            cc_cnt  <= '0;
            ready_q <= 1'b0;
            lv_q    <= 1'b0;
            ld_q    <= '0;
            li_q    <= 1'b1;
            lc_q    <= 1'b0;
        end else begin
            state   <= next_state;
            gb_cnt  <= next_gb_cnt;
            cc_cnt  <= next_cc_cnt;
            ready_q <= next_ready;
            lv_q    <= next_lv;
            ld_q    <= next_ld;
            li_q    <= next_li;
            lc_q    <= next_lc;
        end
    end

    assign link.tx_ready = ready_q;
    assign line_valid    = lv_q;
    assign line_data     = ld_q;
    assign line_idle     = li_q;
    assign line_comp     = lc_q;

    // ----------------------------------------------------------------
    // Receive: no back-pressure, one cycle per word
    // ----------------------------------------------------------------
    logic  rv_q;
    word_t rd_q;
    logic  next_rv;
    word_t next_rd;

    always_comb begin
        next_rv = far_valid & up;
        next_rd = far_valid ? far_data : rd_q;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rv_q <= 1'b0;
            rd_q <= '0;
        end else begin
            rv_q <= next_rv;
            rd_q <= next_rd;
        end
    end

    assign link.rx_valid = rv_q;
    assign link.rx_data  = rd_q;

endmodule // stream_core

// ===== rtl/stream_link_defs.svh
// Timing, width and count constants for the streaming link ends
`ifndef STREAM_LINK_DEFS_SVH
`define STREAM_LINK_DEFS_SVH

`define WORD_BYTES          8
`define WORD_WIDTH          64
`define MCLK_MHZ            25
`define INIT_CLK_MHZ        50
`define DEBOUNCE_NS         200
`define DEBOUNCE_CYCLES     ((`DEBOUNCE_NS * `MCLK_MHZ + 999) / 1000)
`define CNT_WIDTH           4
`define GEARBOX_PERIOD      32
`define CC_INTERVAL         10000
`define CC_LENGTH           3
`define CC_WIDTH            14

`endif

// ===== rtl/stream_link_if.sv
// Interface joining the core end and the user end
`timescale 1ns/1ps
interface stream_link_if;
    import stream_link_pkg::*;
    logic  tx_valid;
    word_t tx_data;
    logic  tx_ready;
    logic  rx_valid;
    word_t rx_data;
    logic  init_request;
    logic  clock_not_locked;
    logic  clock_buffer_clear_out;
    logic  clock_status_out;
    logic  channel_up;

    modport core (
        input  tx_valid, tx_data, init_request, clock_not_locked,
        output tx_ready, rx_valid, rx_data, clock_buffer_clear_out,
               clock_status_out, channel_up
    );
    modport user (
        output tx_valid, tx_data, init_request, clock_not_locked,
        input  tx_ready, rx_valid, rx_data, clock_buffer_clear_out,
               clock_status_out, channel_up
    );
endinterface

// ===== rtl/stream_link_pkg.sv
// Types shared by both ends of the streaming link
package stream_link_pkg;
    typedef logic [63:0] word_t;
    typedef enum logic [1:0] {
        ST_DOWN  = 2'b00,
        ST_DATA  = 2'b01,
        ST_PAUSE = 2'b10,
        ST_COMP  = 2'b11
    } tx_state_e;
endpackage

// ===== rtl/stream_user.sv
// User end: feeds transmit words, captures receive words, drives clock lines
`timescale 1ns/1ps
`include "stream_link_defs.svh"

module stream_user
    import stream_link_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       reset,
    stream_link_if.user     link,
    input  wire logic       send_valid,
    input  wire word_t      send_data,
    input  wire logic       init_request,
    input  wire logic       pll_locked,
    output logic            send_ready,
    output logic            got_valid,
    output word_t           got_data,
    output logic            up
);

    // ----------------------------------------------------------------
    // Transmit side: whole words only, held until accepted
    // ----------------------------------------------------------------
    logic  v_q;
    word_t d_q;
    logic  next_v;
    word_t next_d;
    logic  take;

    assign take = ~v_q | link.tx_ready;

    always_comb begin
        next_v = v_q;
        next_d = d_q;
        if (take) begin
            next_v = send_valid;
            next_d = send_valid ? send_data : d_q;
        end
    end

    // ----------------------------------------------------------------
    // Receive side: captured in the cycle it is shown
    // ----------------------------------------------------------------
    logic  gv_q;
    word_t gd_q;
    logic  ir_q;
    logic  nl_q;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            v_q  <= 1'b0;
            d_q  <= '0;
            gv_q <= 1'b0;
            gd_q <= '0;
            ir_q <= 1'b1;
            nl_q <= 1'b1;
        end else begin
            v_q  <= next_v;
            d_q  <= next_d;
            gv_q <= link.rx_valid;
            gd_q <= link.rx_valid ? link.rx_data : gd_q;
            ir_q <= init_request;
            nl_q <= ~pll_locked;
        end
    end

    assign link.tx_valid         = v_q;
    assign link.tx_data          = d_q;
    assign link.init_request     = ir_q;
    assign link.clock_not_locked = nl_q;
    assign send_ready            = take;
    assign got_valid             = gv_q;
    assign got_data              = gd_q;
    assign up                    = link.channel_up;

endmodule // stream_user

// ===== verif/stream_link_props.sv
// Checker on the interface signals between the core end and the user end
`timescale 1ns/1ps
module stream_link_props
    import stream_link_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic init_request,
    input wire logic clock_not_locked,
    input wire logic clock_buffer_clear_out,
    input wire logic channel_up
);
    // ------------------------------------------------------------
    // Counters of quiet init request and of unbroken ready
    // ------------------------------------------------------------
    logic [3:0] low_cnt;
    logic [3:0] next_low_cnt;
    logic [5:0] run_cnt;
    logic [5:0] next_run_cnt;

    always_comb begin
        next_low_cnt = init_request ? 4'h0
                     : low_cnt + {3'h0, low_cnt != 4'hf};
        next_run_cnt = tx_ready ? run_cnt + 6'h01 : 6'h00;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            low_cnt <= 4'h0;
            run_cnt <= 6'h00;
        end else begin
            low_cnt <= next_low_cnt;
            run_cnt <= next_run_cnt;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_reset_quiet: assert property (
        $past(reset) |-> !channel_up && !tx_ready)
        else $error("link active right after reset");
    a_down_quiet: assert property (
        !channel_up && !$past(channel_up) |-> !rx_valid)
        else $error("receive word while channel down");
    a_ready_needs_up: assert property (
        $rose(tx_ready) |-> channel_up)
        else $error("ready raised while channel down");
    a_unlock_quiet: assert property (
        clock_buffer_clear_out [*2] |-> !tx_ready)
        else $error("ready high while clock unlocked");
    a_clear_match: assert property (
        clock_buffer_clear_out == clock_not_locked)
        else $error("clear out and not locked disagree");
    a_stall_short: assert property (
        channel_up && !clock_buffer_clear_out && $fell(tx_ready)
        |-> ##[1:4] tx_ready)
        else $error("ready stall too long");
    a_ready_run: assert property (
        run_cnt <= 6'h20)
        else $error("no gearbox pause within period");
    a_debounce_len: assert property (
        $rose(channel_up) |-> low_cnt >= 4'h5)
        else $error("channel up before init debounce");
endmodule // stream_link_props

// ===== verif/tb_serial_link_stream_clocking.sv
// Self-checking bench joining the core end and the user end
`timescale 1ns/1ps
module tb_serial_link_stream_clocking;
    import stream_link_pkg::*;
    logic  mclk          = 1'b0;
    logic  reset         = 1'b1;
    logic  helper_active = 1'b0;
    logic  pll           = 1'b1;
    logic  far_valid     = 1'b0;
    word_t far_data      = '0;
    logic  send_valid    = 1'b0;
    word_t send_data     = '0;
    logic  init_req      = 1'b1;
    logic  send_ready, got_valid, up, line_valid, line_idle, line_comp;
    word_t got_data, line_data;
    word_t tx_q[$];
    word_t rx_q[$];
    int    error_cnt = 0;
    int    cmp_count = 0;
    int    cyc       = 0;
    int    idle_seen = 0;
    logic  sync_clk  = 1'b0;
    int    sync_cnt  = 0;

    stream_link_if link ();
    stream_core i_stream_core (.mclk(mclk), .reset(reset), .link(link.core),
        .helper_active(helper_active), .pll_locked(pll),
        .far_valid(far_valid), .far_data(far_data),
        .line_valid(line_valid), .line_data(line_data),
        .line_idle(line_idle), .line_comp(line_comp));
    stream_user i_stream_user (.mclk(mclk), .reset(reset), .link(link.user),
        .send_valid(send_valid), .send_data(send_data),
        .init_request(init_req), .pll_locked(pll),
        .send_ready(send_ready), .got_valid(got_valid),
        .got_data(got_data), .up(up));
    stream_link_props i_stream_link_props (.mclk(mclk), .reset(reset),
        .tx_ready(link.tx_ready), .rx_valid(link.rx_valid),
        .init_request(link.init_request),
        .clock_not_locked(link.clock_not_locked),
        .clock_buffer_clear_out(link.clock_buffer_clear_out),
        .channel_up(link.channel_up));

    // ------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------
    always #20 mclk = ~mclk;

    // Transceiver sync clock at twice the user clock rate
    always #10 sync_clk = ~sync_clk;
    always @(posedge sync_clk) sync_cnt++;

    task automatic final_report();
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic cmp_word(input word_t got, input word_t exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_word({63'h0, got}, {63'h0, exp});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Holds the word until an edge that sees send_ready high
    task automatic send(input word_t d);
        logic ok;
        ok = 1'b0;
        send_valid = 1'b1;
        send_data = d;
        tx_q.push_back(d);
        for (int i = 0; i < 50 && !ok; i++) begin
            @(negedge mclk);
            ok = (send_ready === 1'b1);
            tick(1);
        end
        cmp_bit(ok, 1'b1);
    endtask

    // Line and receive words are compared in order as they appear
    always @(negedge mclk) begin
        if (line_valid === 1'b1) begin
            if (tx_q.size() == 0) cmp_bit(1'b1, 1'b0);
            else cmp_word(line_data, tx_q.pop_front());
        end
        if (got_valid === 1'b1) begin
            if (rx_q.size() == 0) cmp_bit(1'b1, 1'b0);
            else cmp_word(got_data, rx_q.pop_front());
        end
        if (line_idle === 1'b1) idle_seen++;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        tick(2);
        reset = 1'b0;
        cmp_bit(up, 1'b0);
        init_req = 1'b0;
        helper_active = 1'b1;
        for (n = 0; n < 40 && up !== 1'b1; n++) tick(1);
        cmp_bit(up, 1'b1);
        cmp_bit(n >= 5, 1'b1);
        cmp_bit(link.clock_status_out, 1'b1);
        cmp_bit(link.clock_not_locked, 1'b0);
        cmp_bit(link.clock_buffer_clear_out, 1'b0);
        tick(2);
        for (int i = 0; i < 40; i++) send({32'hc0de0000, i});
        for (int i = 0; i < 6; i++) begin
            send({32'hbeef0000, i});
            send_valid = 1'b0;
            n = idle_seen;
            tick(3);
            cmp_bit(idle_seen > n, 1'b1);
        end
        for (n = 0; n < 10100 && line_comp !== 1'b1; n++) tick(1);
        cmp_bit(line_comp, 1'b1);
        cmp_bit(line_idle, 1'b0);
        for (int i = 0; i < 4; i++) send({32'h5a5a0000, i});
        send_valid = 1'b0;
        for (int i = 0; i < 6; i++) begin
            far_valid = 1'b1;
            far_data = {32'hfeed0000, i};
            rx_q.push_back(far_data);
            tick(1);
        end
        far_valid = 1'b0;
        far_data = ~far_data;
        tick(4);
        cmp_bit(rx_q.size() == 0, 1'b1);
        cmp_bit(tx_q.size() == 0, 1'b1);
        pll = 1'b0;
        tick(4);
        cmp_bit(link.tx_ready, 1'b0);
        cmp_bit(link.clock_buffer_clear_out, 1'b1);
        cmp_bit(link.clock_not_locked, 1'b1);
        cmp_bit(up, 1'b0);
        far_valid = 1'b1;
        helper_active = 1'b0;
        tick(3);
        cmp_bit(link.clock_status_out, 1'b0);
        far_valid = 1'b0;
        tick(3);
        cmp_bit(sync_cnt == 2 * cyc - 1, 1'b1);
        final_report();
    end
endmodule // tb_serial_link_stream_clocking
